// ### rtl/rcp_params.svh
/*
 Constants for the remote control port: clock rate, drive pulse length,
 reset level of the filtered remote lines.
 Assumes rcp_lines_s field order: prepare, start, shutdown, power_on,
 ready, stop, start_request (MSB first).
*/
`ifndef RCP_PARAMS_SVH
`define RCP_PARAMS_SVH

// System clock period
`define RCP_CLK_PERIOD_NS 100

// Least time a request is pulled low on a shared line
`define RCP_PULSE_TIME_NS 2000

// Least time rounded up to whole cycles
`define RCP_PULSE_CYC ((`RCP_PULSE_TIME_NS + `RCP_CLK_PERIOD_NS - 1) / `RCP_CLK_PERIOD_NS)

// Filtered line levels at reset: low-true lines idle high, others low
`define RCP_LINES_IDLE 7'h73

// Output enables at reset: nothing pulled
`define RCP_OE_RESET 7'h00

`endif

// ### rtl/rcp_pkg.sv
/*
 Types of the remote control port: the bundle of shared lines,
 the run state and the registered state of the core.
 Assumes nothing beyond the parameter header.
*/
package rcp_pkg;

    // One bit per shared remote line
    typedef struct packed {
        logic prepare;
        logic start;
        logic shutdown;
        logic power_on;
        logic ready;
        logic stop;
        logic start_request;
    } rcp_lines_s;

    typedef enum logic [1:0] {
        rcp_st_idle,
        rcp_st_prep,
        rcp_st_run
    } rcp_run_e;

    typedef struct packed {
        rcp_run_e   run;
        rcp_lines_s prev;
        rcp_lines_s oe;
        logic       prep_begin;
        logic       run_begin;
        logic       run_end;
        logic       run_abort;
        logic       inject_req;
        logic       power_lost;
        logic       ready_rise;
        logic       protect;
    } rcp_core_s;

endpackage : rcp_pkg

// ### rtl/rcp_sync.sv
/*
 Three-stage input filter for levels from outside the clock domain.
 A level is taken once stages two and three agree.
 Assumes a synchronous active-high reset.
*/
`timescale 1ns/10ps
module rcp_sync #(
    parameter int               WIDTH     = 7,
    parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
    // Clock and reset
    input  wire logic             i_clock,
    input  wire logic             i_rst,
    // Raw and filtered levels
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_level
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] lvl;
    } rcp_sync_state_s;

    rcp_sync_state_s st_q;
    rcp_sync_state_s st_d;

    generate
        if (WIDTH < 1) begin : g_bad_width
            $error("rcp_sync width must be at least one");
        end
    endgenerate

    always_comb begin
        st_d     = st_q;
        st_d.s1  = i_async;
        st_d.s2  = st_q.s1;
        st_d.s3  = st_q.s2;
        st_d.lvl = (~(st_q.s2 ^ st_q.s3) & st_q.s3) | ((st_q.s2 ^ st_q.s3) & st_q.lvl);
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            st_q <= '{RESET_VAL, RESET_VAL, RESET_VAL, RESET_VAL};
        end else begin
            st_q <= st_d;
        end
    end

    assign o_level = st_q.lvl;

    a_sync_agree: assert property (@(posedge i_clock) disable iff (i_rst)
        (st_q.s2 == st_q.s3) |=> (o_level == $past(st_q.s3)))
        else $error("filtered level missed an agreed input");

endmodule : rcp_sync

// ### rtl/rcp_pulse_drv.sv
/*
 Pulse stretcher for one open-collector request line.
 A fire while idle pulls the line for CYCLES clocks; fires while busy are ignored.
 Assumes a synchronous active-high reset.
*/
`timescale 1ns/10ps
`include "rcp_params.svh"
module rcp_pulse_drv #(
    parameter int CYCLES = `RCP_PULSE_CYC
) (
    // Clock and reset
    input  wire logic i_clock,
    input  wire logic i_rst,
    // Request and drive
    input  wire logic i_fire,
    output logic      o_drive
);
    localparam int CW     = $clog2(CYCLES + 1);
    localparam int LAST_C = CYCLES - 1;

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic          drive;
    } rcp_pulse_state_s;

    rcp_pulse_state_s st_q;
    rcp_pulse_state_s st_d;

    generate
        if (CYCLES < 1 || CYCLES > 65535) begin : g_bad_cycles
            $error("rcp_pulse_drv cycles out of range");
        end
    endgenerate

    always_comb begin
        st_d = st_q;
        if (i_fire && (st_q.cnt == '0)) begin
            st_d.cnt = CW'(CYCLES);
        end else if (st_q.cnt != '0) begin
            st_d.cnt = st_q.cnt - 1'b1;
        end
        st_d.drive = (st_d.cnt != '0);
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            st_q <= '{cnt: '0, drive: 1'b0};
        end else begin
            st_q <= st_d;
        end
    end

    assign o_drive = st_q.drive;

    a_pulse_start: assert property (@(posedge i_clock) disable iff (i_rst)
        (i_fire && !o_drive) |=> o_drive)
        else $error("request fire did not pull the line");

    a_pulse_width: assert property (@(posedge i_clock) disable iff (i_rst)
        $rose(o_drive) |-> ##LAST_C o_drive ##1 !o_drive)
        else $error("line pulse length wrong");

endmodule : rcp_pulse_drv

// ### rtl/rcp_remote_port.sv
/*
 Remote control port core: drives the shared wired-or remote lines by
 open-collector enables and reacts to the filtered levels seen on them.
 Assumes an external pull-up on every line and a wire resolved from
 o_line_oe; o_line_out is the level driven while enabled.
*/
// Functional notes
// - Low means asserted, except power-on and ready which are asserted high.
// - Lines are only pulled low through open-collector enables, wired-or.
// - A serious local fault pulls the shared shutdown line low.
// - Seeing shutdown low raises the protective action output, e.g. pump stop.
// - Power-on reads high only when every module is on; we pull it otherwise.
// - Ready first, then start, then optional stop, each on its own line.
// - Ready high means the system can take the next analysis.
// - Prepare going low begins pre-analysis activity.
// - Start going low begins the run or timetable.
// - Stop going low returns the device to ready, aborting the run.
// - Start-request low asks for an injection; only an autosampler acts.
`timescale 1ns/10ps
`include "rcp_params.svh"
module rcp_remote_port #(
    parameter bit P_DOES_PREP   = 1'b1,
    parameter bit P_DOES_RUN    = 1'b1,
    parameter bit P_CAN_PROTECT = 1'b1,
    parameter bit P_IS_SAMPLER  = 1'b0,
    parameter int P_PULSE_CYC   = `RCP_PULSE_CYC
) (
    // Clock and reset
    input  wire logic               i_clock,
    input  wire logic               i_rst,
    // Shared remote lines
    input  wire rcp_pkg::rcp_lines_s i_line_in,
    output rcp_pkg::rcp_lines_s      o_line_out,
    output rcp_pkg::rcp_lines_s      o_line_oe,
    // Local conditions
    input  wire logic               i_fault,
    input  wire logic               i_local_on,
    input  wire logic               i_local_ready,
    // Local requests
    input  wire logic               i_req_prepare,
    input  wire logic               i_req_start,
    input  wire logic               i_req_stop,
    input  wire logic               i_req_inject,
    // Local completions
    input  wire logic               i_prep_done,
    input  wire logic               i_run_done,
    input  wire logic               i_protect_clear,
    // System levels
    output rcp_pkg::rcp_lines_s      o_lines,
    output logic                    o_sys_shutdown,
    output logic                    o_sys_on,
    output logic                    o_sys_ready,
    // Device state
    output logic                    o_preparing,
    output logic                    o_running,
    output logic                    o_protect,
    // Event pulses
    output logic                    o_prep_begin,
    output logic                    o_run_begin,
    output logic                    o_run_end,
    output logic                    o_run_abort,
    output logic                    o_inject_req,
    output logic                    o_power_lost,
    output logic                    o_ready_rise
);
    localparam int NREQ = 4;

    rcp_pkg::rcp_lines_s lvl;
    rcp_pkg::rcp_core_s  core_q;
    rcp_pkg::rcp_core_s  core_d;

    logic [NREQ-1:0] fire;
    logic [NREQ-1:0] drive;
    logic            fall_prep;
    logic            fall_start;
    logic            fall_stop;
    logic            fall_inj;
    logic            fall_pwr;
    logic            rise_ready;
    logic            shut;

    generate
        if (P_PULSE_CYC < 1) begin : g_bad_pulse
            $error("rcp_remote_port pulse length must be at least one cycle");
        end
    endgenerate

    // Incoming level filter
    rcp_sync #(
        .WIDTH     (7),
        .RESET_VAL (`RCP_LINES_IDLE)
    ) u_sync (
        .i_clock (i_clock),
        .i_rst   (i_rst),
        .i_async (i_line_in),
        .o_level (lvl)
    );

    // Request stretchers: prepare, start, stop, start-request
    generate
        for (genvar g = 0; g < NREQ; g++) begin : g_req
            rcp_pulse_drv #(
                .CYCLES (P_PULSE_CYC)
            ) u_drv (
                .i_clock (i_clock),
                .i_rst   (i_rst),
                .i_fire  (fire[g]),
                .o_drive (drive[g])
            );
        end
    endgenerate

    // Edges on the filtered levels, and the shutdown level itself
    assign fall_prep  = core_q.prev.prepare & ~lvl.prepare;
    assign fall_start = core_q.prev.start & ~lvl.start;
    assign fall_stop  = core_q.prev.stop & ~lvl.stop;
    assign fall_inj   = core_q.prev.start_request & ~lvl.start_request;
    assign fall_pwr   = core_q.prev.power_on & ~lvl.power_on;
    assign rise_ready = ~core_q.prev.ready & lvl.ready;
    assign shut       = ~lvl.shutdown;

    // Outgoing requests, in the legal order
    assign fire[0] = i_req_prepare && (core_q.run != rcp_pkg::rcp_st_run);
    assign fire[1] = i_req_start && lvl.ready && !shut
                     && (core_q.run != rcp_pkg::rcp_st_run);
    assign fire[2] = i_req_stop && (core_q.run == rcp_pkg::rcp_st_run);
    assign fire[3] = i_req_inject;

    always_comb begin
        core_d            = core_q;
        core_d.prev       = lvl;
        core_d.prep_begin = 1'b0;
        core_d.run_begin  = 1'b0;
        core_d.run_end    = 1'b0;
        core_d.run_abort  = 1'b0;
        core_d.inject_req = fall_inj && P_IS_SAMPLER;
        core_d.power_lost = fall_pwr;
        core_d.ready_rise = rise_ready;

        unique case (core_q.run)
            rcp_pkg::rcp_st_idle: begin
                if (!shut && fall_start && P_DOES_RUN) begin
                    core_d.run       = rcp_pkg::rcp_st_run;
                    core_d.run_begin = 1'b1;
                end else if (!shut && fall_prep && P_DOES_PREP) begin
                    core_d.run        = rcp_pkg::rcp_st_prep;
                    core_d.prep_begin = 1'b1;
                end
            end
            rcp_pkg::rcp_st_prep: begin
                if (shut || fall_pwr) begin
                    core_d.run       = rcp_pkg::rcp_st_idle;
                    core_d.run_abort = 1'b1;
                end else if (fall_start && P_DOES_RUN) begin
                    core_d.run       = rcp_pkg::rcp_st_run;
                    core_d.run_begin = 1'b1;
                end else if (i_prep_done) begin
                    core_d.run = rcp_pkg::rcp_st_idle;
                end
            end
            rcp_pkg::rcp_st_run: begin
                if (shut || fall_stop || fall_pwr) begin
                    core_d.run       = rcp_pkg::rcp_st_idle;
                    core_d.run_abort = 1'b1;
                end else if (i_run_done) begin
                    core_d.run     = rcp_pkg::rcp_st_idle;
                    core_d.run_end = 1'b1;
                end
            end
            default: begin
                core_d.run = rcp_pkg::rcp_st_idle;
            end
        endcase

        // Protective action holds until cleared with the line released
        core_d.protect = P_CAN_PROTECT
                         && (shut || (core_q.protect && !i_protect_clear));

        // Open-collector enables: high pulls the line low
        core_d.oe.prepare       = drive[0];
        core_d.oe.start         = drive[1];
        core_d.oe.stop          = drive[2];
        core_d.oe.start_request = drive[3];
        core_d.oe.shutdown      = i_fault;
        core_d.oe.power_on      = !i_local_on;
        core_d.oe.ready         = !(i_local_ready
                                    && (core_d.run == rcp_pkg::rcp_st_idle));
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            core_q <= '{
                run:        rcp_pkg::rcp_st_idle,
                prev:       `RCP_LINES_IDLE,
                oe:         `RCP_OE_RESET,
                prep_begin: 1'b0,
                run_begin:  1'b0,
                run_end:    1'b0,
                run_abort:  1'b0,
                inject_req: 1'b0,
                power_lost: 1'b0,
                ready_rise: 1'b0,
                protect:    1'b0
            };
        end else begin
            core_q <= core_d;
        end
    end

    // Pins only ever pull to 0 V
    assign o_line_out     = '0;
    assign o_line_oe      = core_q.oe;
    assign o_lines        = lvl;
    assign o_sys_shutdown = shut;
    assign o_sys_on       = lvl.power_on;
    assign o_sys_ready    = lvl.ready;
    assign o_preparing    = (core_q.run == rcp_pkg::rcp_st_prep);
    assign o_running      = (core_q.run == rcp_pkg::rcp_st_run);
    assign o_protect      = core_q.protect;
    assign o_prep_begin   = core_q.prep_begin;
    assign o_run_begin    = core_q.run_begin;
    assign o_run_end      = core_q.run_end;
    assign o_run_abort    = core_q.run_abort;
    assign o_inject_req   = core_q.inject_req;
    assign o_power_lost   = core_q.power_lost;
    assign o_ready_rise   = core_q.ready_rise;

    a_shut_drive: assert property (@(posedge i_clock) disable iff (i_rst)
        i_fault |=> o_line_oe.shutdown)
        else $error("fault did not pull shutdown");

    a_protect_act: assert property (@(posedge i_clock) disable iff (i_rst)
        (P_CAN_PROTECT && !i_line_in.shutdown)[*5] |-> ##[0:2] o_protect)
        else $error("shutdown low without protective action");

    a_power_drive: assert property (@(posedge i_clock) disable iff (i_rst)
        !i_local_on |=> (o_line_oe.power_on && !o_line_out.power_on))
        else $error("power-on not pulled while off");

    a_start_order: assert property (@(posedge i_clock) disable iff (i_rst)
        $rose(o_line_oe.start) |-> $past(o_sys_ready, 3))
        else $error("start driven without system ready");

    a_ready_busy: assert property (@(posedge i_clock) disable iff (i_rst)
        (o_running || o_preparing) |-> o_line_oe.ready)
        else $error("ready released while busy");

    a_prep_begin: assert property (@(posedge i_clock) disable iff (i_rst)
        (P_DOES_PREP && (core_q.run == rcp_pkg::rcp_st_idle) && fall_prep
         && !fall_start && !shut) |=> (o_prep_begin && o_preparing))
        else $error("prepare edge did not begin preparation");

    a_run_begin: assert property (@(posedge i_clock) disable iff (i_rst)
        (P_DOES_RUN && !o_running && fall_start && !shut && !fall_pwr)
        |=> (o_run_begin && o_running))
        else $error("start edge did not begin the run");

    a_stop_abort: assert property (@(posedge i_clock) disable iff (i_rst)
        (o_running && fall_stop) |=> (!o_running && o_run_abort))
        else $error("stop edge did not abort the run");

    a_inject_gate: assert property (@(posedge i_clock) disable iff (i_rst)
        o_inject_req |-> (P_IS_SAMPLER && $past(fall_inj)))
        else $error("injection request without sampler role or edge");

    a_power_free: assert property (@(posedge i_clock) disable iff (i_rst)
        i_local_on |=> !o_line_oe.power_on)
        else $error("power-on pulled while on");

    a_shut_free: assert property (@(posedge i_clock) disable iff (i_rst)
        !i_fault |=> !o_line_oe.shutdown)
        else $error("shutdown pulled without fault");

    a_ready_idle: assert property (@(posedge i_clock) disable iff (i_rst)
        (!o_running && !o_preparing && $past(i_local_ready)) |-> !o_line_oe.ready)
        else $error("ready pulled while idle and ready");

    a_prep_in_run: assert property (@(posedge i_clock) disable iff (i_rst)
        (o_running && fall_prep) |=> !o_preparing)
        else $error("prepare taken during run");

    a_run_end: assert property (@(posedge i_clock) disable iff (i_rst)
        (o_running && i_run_done && !shut && !fall_stop && !fall_pwr)
        |=> (o_run_end && !o_running))
        else $error("run done did not end the run");

    a_protect_hold: assert property (@(posedge i_clock) disable iff (i_rst)
        (o_protect && !i_protect_clear) |=> o_protect)
        else $error("protective action dropped without clear");

    a_shut_abort: assert property (@(posedge i_clock) disable iff (i_rst)
        (o_running && shut) |=> (!o_running && o_run_abort))
        else $error("shutdown did not abort the run");

endmodule : rcp_remote_port

// ### bench/rcp_far_side.sv
/*
 Far side of the remote control port: the other instruments on the shared
 lines, including an injector that answers an injection request with a start.
 Assumes the device drives open-collector enables; every line has a pull-up.
*/
`timescale 1ns/10ps
module rcp_far_side (
    // Clock and reset
    input  wire logic                i_clock,
    input  wire logic                i_rst,
    // Pulls ordered by the bench and by the device
    input  wire rcp_pkg::rcp_lines_s i_pull,
    input  wire rcp_pkg::rcp_lines_s i_dut_oe,
    input  wire logic [7:0]          i_delay,
    // Resolved wire levels
    output rcp_pkg::rcp_lines_s      o_wire
);
    logic                prev_q;
    logic                armed_q;
    logic [7:0]          wait_q;
    logic [3:0]          hold_q;
    rcp_pkg::rcp_lines_s own;

    always_comb begin
        own = '0;
        own.start = (hold_q != 4'h0);
    end

    // Any party pulling makes the line low, otherwise the pull-up wins
    assign o_wire = rcp_pkg::rcp_lines_s'(~(i_pull | i_dut_oe | own));

    // Injector: a fall of the request starts a run by pulling start i_delay + 2 cycles later
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            prev_q  <= 1'b1;
            armed_q <= 1'b0;
            wait_q  <= 8'h00;
            hold_q  <= 4'h0;
        end else begin
            prev_q <= o_wire.start_request;
            if (hold_q != 4'h0) begin
                hold_q <= hold_q - 4'h1;
            end
            if (armed_q) begin
                if (wait_q == 8'h00) begin
                    armed_q <= 1'b0;
                    hold_q  <= 4'h6;
                end else begin
                    wait_q <= wait_q - 8'h01;
                end
            end else if (prev_q && !o_wire.start_request && o_wire.ready) begin
                armed_q <= 1'b1;
                wait_q  <= i_delay;
            end
        end
    end
endmodule : rcp_far_side

// ### bench/test_remote_control_lines.sv
/*
 Testbench of the remote control port: scenario tasks drive the local side
 and the far side model, and judge levels, pulse counts and latencies.
 Assumes the design defaults except a short request pulse.
*/
`timescale 1ns/10ps
`include "rcp_params.svh"
module test_remote_control_lines;
    localparam int PULSE = 4;
    localparam int K_PREPB = 0, K_RUNB = 1, K_RUNE = 2, K_ABORT = 3, K_INJ = 4;
    localparam int K_PLOST = 5, K_RRISE = 6, K_PREP = 7, K_RUN = 8, K_PROT = 9;
    localparam int K_SD = 10, K_ON = 11, K_RDY = 12, K_OSTA = 13, K_OSTO = 14;
    localparam int K_OINJ = 15, K_OSD = 16, K_OPWR = 17, K_ORDY = 18;

    logic                i_clock, i_rst, i_fault, i_local_on, i_local_ready;
    logic                i_req_prepare, i_req_start, i_req_stop, i_req_inject;
    logic                i_prep_done, i_run_done, i_protect_clear;
    logic                o_sys_shutdown, o_sys_on, o_sys_ready, o_preparing;
    logic                o_running, o_protect, o_prep_begin, o_run_begin, o_run_end;
    logic                o_run_abort, o_inject_req, o_power_lost, o_ready_rise;
    rcp_pkg::rcp_lines_s line_wire, far_pull, o_line_out, o_line_oe, o_lines;
    logic [7:0]          far_delay;
    logic [31:0]         watch;
    int                  err_count, samples_checked;
    int                  hits [19];
    int                  snap [19];

    rcp_remote_port #(.P_PULSE_CYC(PULSE)) dut (
        .i_clock(i_clock), .i_rst(i_rst), .i_line_in(line_wire),
        .o_line_out(o_line_out), .o_line_oe(o_line_oe), .i_fault(i_fault),
        .i_local_on(i_local_on), .i_local_ready(i_local_ready),
        .i_req_prepare(i_req_prepare), .i_req_start(i_req_start),
        .i_req_stop(i_req_stop), .i_req_inject(i_req_inject),
        .i_prep_done(i_prep_done), .i_run_done(i_run_done),
        .i_protect_clear(i_protect_clear), .o_lines(o_lines),
        .o_sys_shutdown(o_sys_shutdown), .o_sys_on(o_sys_on),
        .o_sys_ready(o_sys_ready), .o_preparing(o_preparing),
        .o_running(o_running), .o_protect(o_protect),
        .o_prep_begin(o_prep_begin), .o_run_begin(o_run_begin),
        .o_run_end(o_run_end), .o_run_abort(o_run_abort),
        .o_inject_req(o_inject_req), .o_power_lost(o_power_lost),
        .o_ready_rise(o_ready_rise));

    rcp_far_side u_far (.i_clock(i_clock), .i_rst(i_rst), .i_pull(far_pull),
        .i_dut_oe(o_line_oe), .i_delay(far_delay), .o_wire(line_wire));

    assign watch = {13'h0000, o_line_oe.ready, o_line_oe.power_on, o_line_oe.shutdown,
        o_line_oe.start_request, o_line_oe.stop, o_line_oe.start, o_sys_ready,
        o_sys_on, o_sys_shutdown, o_protect, o_running, o_preparing, o_ready_rise,
        o_power_lost, o_inject_req, o_run_abort, o_run_end, o_run_begin, o_prep_begin};

    always #50 i_clock = ~i_clock;

    // Pulses counted where outputs are settled
    always @(negedge i_clock) begin
        for (int k = 0; k < 19; k++) begin
            if (watch[k] === 1'b1) hits[k]++;
        end
    end

    task automatic tally_and_finish();
        $display("Checks made: %0d, mismatches: %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk

    task automatic hit(input int k, input int exp, input string what);
        @(negedge i_clock);
        #1 chk(what, exp, hits[k] - snap[k]);
    endtask : hit

    // Waits for a level, counting edges; too early or too late is a mismatch
    task automatic wait_bit(input int k, input logic v, input int lo, input int hi,
                            input string what);
        int n;
        n = 0;
        do begin
            @(posedge i_clock);
            #1;
            n++;
        end while (watch[k] !== v && n < hi);
        samples_checked++;
        if (watch[k] !== v || n < lo) begin
            err_count++;
            $display("[ERR] %s expected in %0d..%0d cycles seen at %0d", what, lo, hi, n);
            if (watch[k] !== v) tally_and_finish();
        end
    endtask : wait_bit

    task automatic t_power();
        snap = hits;
        @(posedge i_clock) far_pull.power_on <= 1'b1;
        wait_bit(K_ON, 1'b0, 4, 8, "sys_on far off");
        @(posedge i_clock) far_pull.power_on <= 1'b0;
        wait_bit(K_ON, 1'b1, 4, 8, "sys_on far back");
        hit(K_PLOST, 1, "power_lost pulses");
        @(posedge i_clock) i_local_on <= 1'b0;
        wait_bit(K_OPWR, 1'b1, 1, 2, "own power pull");
        wait_bit(K_ON, 1'b0, 1, 8, "sys_on own off");
        @(posedge i_clock) i_local_on <= 1'b1;
        wait_bit(K_ON, 1'b1, 1, 8, "sys_on own back");
    endtask : t_power

    task automatic t_own_run();
        @(posedge i_clock) far_pull.ready <= 1'b1;
        wait_bit(K_RDY, 1'b0, 4, 8, "sys_ready far busy");
        @(posedge i_clock) i_req_start <= 1'b1;
        @(posedge i_clock) i_req_start <= 1'b0;
        @(posedge i_clock) i_req_stop <= 1'b1;
        @(posedge i_clock) i_req_stop <= 1'b0;
        repeat (3) @(posedge i_clock);
        #1 chk("start or stop drive refused", 0, watch[K_OSTO:K_OSTA]);
        @(posedge i_clock) far_pull.ready <= 1'b0;
        wait_bit(K_RDY, 1'b1, 4, 8, "sys_ready back");
        snap = hits;
        @(posedge i_clock) i_req_start <= 1'b1;
        @(posedge i_clock);
        @(posedge i_clock) i_req_start <= 1'b0;
        wait_bit(K_OSTA, 1'b1, 1, 3, "start drive");
        wait_bit(K_OSTA, 1'b0, 1, PULSE, "start drive end");
        hit(K_OSTA, PULSE, "start drive length");
        wait_bit(K_RUN, 1'b1, 0, 10, "own run");
        hit(K_RUNB, 1, "run_begin pulses");
        chk("ready pulled in run", 1, watch[K_ORDY]);
        @(posedge i_clock) i_req_stop <= 1'b1;
        @(posedge i_clock) i_req_stop <= 1'b0;
        wait_bit(K_OSTO, 1'b1, 1, 3, "stop drive");
        wait_bit(K_RUN, 1'b0, 1, 10, "run stopped");
        hit(K_ABORT, 1, "run_abort pulses");
        wait_bit(K_RDY, 1'b1, 1, 12, "ready again");
        @(posedge i_clock);
        #1 hit(K_RRISE, 2, "ready_rise pulses");
    endtask : t_own_run

    task automatic t_prepare();
        snap = hits;
        @(posedge i_clock) far_pull.prepare <= 1'b1;
        wait_bit(K_PREP, 1'b1, 4, 8, "preparing");
        hit(K_PREPB, 1, "prep_begin pulses");
        chk("ready pulled in prepare", 1, watch[K_ORDY]);
        @(posedge i_clock) far_pull.prepare <= 1'b0;
        i_prep_done <= 1'b1;
        @(posedge i_clock) i_prep_done <= 1'b0;
        wait_bit(K_PREP, 1'b0, 0, 3, "prepare done");
        hit(K_ABORT, 0, "no abort on done");
    endtask : t_prepare

    task automatic t_far_run();
        snap = hits;
        @(posedge i_clock) far_pull.start <= 1'b1;
        wait_bit(K_RUN, 1'b1, 4, 8, "far start");
        @(posedge i_clock) far_pull.start <= 1'b0;
        far_pull.stop <= 1'b1;
        wait_bit(K_RUN, 1'b0, 4, 8, "far stop");
        @(posedge i_clock) far_pull.stop <= 1'b0;
        hit(K_ABORT, 1, "far stop aborts");
        hit(K_RUNB, 1, "far run_begin");
    endtask : t_far_run

    task automatic t_shutdown();
        snap = hits;
        @(posedge i_clock) i_fault <= 1'b1;
        wait_bit(K_OSD, 1'b1, 1, 2, "shutdown pull");
        wait_bit(K_PROT, 1'b1, 1, 8, "protect on");
        chk("sys_shutdown", 1, watch[K_SD]);
        @(posedge i_clock) far_pull.start <= 1'b1;
        repeat (8) @(posedge i_clock);
        #1 chk("no run in shutdown", 0, watch[K_RUN]);
        @(posedge i_clock) far_pull.start <= 1'b0;
        i_fault <= 1'b0;
        wait_bit(K_SD, 1'b0, 1, 8, "shutdown gone");
        chk("protect held", 1, watch[K_PROT]);
        @(posedge i_clock) i_protect_clear <= 1'b1;
        @(posedge i_clock) i_protect_clear <= 1'b0;
        wait_bit(K_PROT, 1'b0, 0, 3, "protect cleared");
    endtask : t_shutdown

    task automatic t_inject(input logic [7:0] d);
        snap = hits;
        @(posedge i_clock) far_delay <= d;
        i_req_inject <= 1'b1;
        @(posedge i_clock) i_req_inject <= 1'b0;
        wait_bit(K_OINJ, 1'b1, 1, 3, "inject drive");
        wait_bit(K_RUN, 1'b1, 4, 40, "injected run");
        hit(K_INJ, 0, "inject_req not sampler");
        @(posedge i_clock) i_run_done <= 1'b1;
        @(posedge i_clock) i_run_done <= 1'b0;
        wait_bit(K_RUN, 1'b0, 0, 3, "run done");
        hit(K_RUNE, 1, "run_end pulses");
    endtask : t_inject

    initial begin
        {i_clock, i_fault, i_req_prepare, i_req_start, i_req_stop} = '0;
        {i_req_inject, i_prep_done, i_run_done, i_protect_clear} = '0;
        {i_rst, i_local_on, i_local_ready} = 3'h7;
        far_pull = '0;
        far_delay = 8'h00;
        err_count = 0;
        samples_checked = 0;
        hits = '{default: 0};
        snap = '{default: 0};
        repeat (2) @(posedge i_clock);
        i_rst <= 1'b0;
        #1 chk("oe in reset", 0, o_line_oe);
        chk("lines in reset", `RCP_LINES_IDLE, o_lines);
        chk("line out", 0, o_line_out);
        wait_bit(K_ON, 1'b1, 1, 10, "all on");
        wait_bit(K_RDY, 1'b1, 0, 10, "system ready");
        chk("oe idle", 0, o_line_oe);
        t_power();
        t_own_run();
        t_prepare();
        t_far_run();
        t_shutdown();
        t_inject(8'h00);
        t_inject(8'h0c);
        tally_and_finish();
    end
endmodule : test_remote_control_lines
